// ==== shared/ibcw_pkg.sv ====
`default_nettype none
package ibcw_pkg;
  // Register map
  localparam logic [7:0] ADDR_CTRL2 = 8'h22;
  localparam logic [7:0] ADDR_SCRATCH = 8'h23;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  // Field positions in the second link control register
  localparam int BIT_SEQ_ERR = 7;
  localparam int BIT_CLR_SEQ = 6;
  localparam int BIT_DLY_HI = 4;
  localparam int BIT_DLY_LO = 3;
  localparam int BIT_WR_BLOCK = 2;
  localparam int BIT_SPEEDUP = 1;
  localparam int BIT_WD_DIS = 0;
  // Clock
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // SDA output delay: base plus one step per code
  localparam int SDA_DLY_BASE_NS = 350;
  localparam int SDA_DLY_STEP_NS = 50;
  localparam int SDA_DLY_BASE_CYC = (SDA_DLY_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDA_DLY_STEP_CYC = (SDA_DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDA_DLY_MAX_CYC = SDA_DLY_BASE_CYC + 3 * SDA_DLY_STEP_CYC;
  // Watchdog intervals
  localparam int WD_SHORT_US = 50;
  localparam int WD_LONG_S = 1;
  localparam int WD_SHORT_CYC = WD_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int WD_LONG_CYC = WD_LONG_S * CLK_HZ;
  localparam int WD_CNT_W = 25;
  // Bus recovery clocking
  localparam int RECOV_PULSES = 9;
  localparam int RECOV_HALF_NS = 5000;
  localparam int RECOV_HALF_CYC = RECOV_HALF_NS / CLK_PERIOD_NS;
  // Watchdog states, Gray along idle -> low -> high
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_LOW = 2'b01,
    WD_HIGH = 2'b11
  } ibcw_wd_state_t;
endpackage : ibcw_pkg
`default_nettype wire

// ==== hdl/ibcw_sda_delay.sv ====
`default_nettype none
module ibcw_sda_delay (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Undelayed drive request and delay code
  input wire logic sda_low_req,
  input wire logic [1:0] dly_code,
  // Delayed drive request
  output logic sda_low_dly
);
  localparam int DEPTH = ibcw_pkg::SDA_DLY_MAX_CYC;

  typedef struct packed {
    logic [DEPTH-1:0] line;
    logic out;
  } ibcw_dly_state_t;

  ibcw_dly_state_t s_q, s_d;
  int tap;

  always_comb begin
    tap = ibcw_pkg::SDA_DLY_BASE_CYC + int'(dly_code) * ibcw_pkg::SDA_DLY_STEP_CYC;
    s_d = s_q;
    s_d.line = {s_q.line[DEPTH-2:0], sda_low_req};
    // Output flop adds one cycle, so tap one position earlier
    s_d.out = s_q.line[tap - 2];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_low_dly = s_q.out;
endmodule : ibcw_sda_delay
`default_nettype wire

// ==== hdl/ibcw_top.sv ====
`default_nettype none
module ibcw_top #(
  parameter int unsigned WD_LONG_CYCLES = ibcw_pkg::WD_LONG_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Local register access port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_remote,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_wr_accept,
  output logic reg_wr_blocked,
  // Forward control channel
  input wire logic seq_err_evt,
  // Local I2C bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // I2C engine SDA drive request
  input wire logic sda_low_req,
  // Bus status and scratch register contents
  output logic bus_free,
  output logic bus_recovering,
  output logic [7:0] scratch_byte
);
  localparam logic [ibcw_pkg::WD_CNT_W-1:0] WD_SHORT_LIM = ibcw_pkg::WD_CNT_W'(ibcw_pkg::WD_SHORT_CYC);
  localparam logic [ibcw_pkg::WD_CNT_W-1:0] WD_LONG_LIM = ibcw_pkg::WD_CNT_W'(WD_LONG_CYCLES);
  localparam logic [7:0] HALF_LAST = 8'(ibcw_pkg::RECOV_HALF_CYC - 1);
  localparam logic [3:0] PULSE_LAST = 4'(ibcw_pkg::RECOV_PULSES - 1);

  typedef struct packed {
    logic seq_err;
    logic clr_bit;
    logic [1:0] sda_dly;
    logic wr_block;
    logic speedup;
    logic wd_dis;
    logic [7:0] scratch;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [ibcw_pkg::WD_CNT_W-1:0] wd_cnt;
    ibcw_pkg::ibcw_wd_state_t st;
    logic [3:0] pulses;
    logic [7:0] half;
    logic bus_free;
    logic [7:0] rdata;
    logic blocked;
  } ibcw_state_t;

  ibcw_state_t s_q, s_d;
  logic sda_low_dly;

  function automatic logic [7:0] ctrl2_image(input ibcw_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[ibcw_pkg::BIT_SEQ_ERR] = s.seq_err;
    v[ibcw_pkg::BIT_CLR_SEQ] = s.clr_bit;
    v[ibcw_pkg::BIT_DLY_HI:ibcw_pkg::BIT_DLY_LO] = s.sda_dly;
    v[ibcw_pkg::BIT_WR_BLOCK] = s.wr_block;
    v[ibcw_pkg::BIT_SPEEDUP] = s.speedup;
    v[ibcw_pkg::BIT_WD_DIS] = s.wd_dis;
    return v;
  endfunction : ctrl2_image

  logic wr_ok;
  logic wr_ctrl2;
  logic bus_edge;
  logic [ibcw_pkg::WD_CNT_W-1:0] wd_lim;

  always_comb begin
    // Only this device's own register file is gated; pass-through traffic never reaches this port
    wr_ok = reg_wr && !(reg_remote && s_q.wr_block);
    wr_ctrl2 = wr_ok && (reg_addr == ibcw_pkg::ADDR_CTRL2);
    bus_edge = (s_q.scl_s != s_q.scl_p) || (s_q.sda_s != s_q.sda_p);
    wd_lim = s_q.speedup ? WD_SHORT_LIM : WD_LONG_LIM;

    s_d = s_q;
    s_d.blocked = reg_wr && !wr_ok;

    // Pin synchronisers and edge history
    s_d.scl_m = scl_i;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = sda_i;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;

    if (wr_ctrl2) begin
      s_d.clr_bit = reg_wdata[ibcw_pkg::BIT_CLR_SEQ];
      s_d.sda_dly = reg_wdata[ibcw_pkg::BIT_DLY_HI:ibcw_pkg::BIT_DLY_LO];
      s_d.wr_block = reg_wdata[ibcw_pkg::BIT_WR_BLOCK];
      s_d.speedup = reg_wdata[ibcw_pkg::BIT_SPEEDUP];
      s_d.wd_dis = reg_wdata[ibcw_pkg::BIT_WD_DIS];
    end
    if (wr_ok && (reg_addr == ibcw_pkg::ADDR_SCRATCH)) begin
      s_d.scratch = reg_wdata;
    end

    // Set wins over a clear in the same cycle so no error is lost
    if (seq_err_evt) begin
      s_d.seq_err = 1'b1;
    end else if (wr_ctrl2 && reg_wdata[ibcw_pkg::BIT_CLR_SEQ]) begin
      s_d.seq_err = 1'b0;
    end

    if (reg_rd) begin
      if (reg_addr == ibcw_pkg::ADDR_CTRL2) begin
        s_d.rdata = ctrl2_image(s_q);
      end else if (reg_addr == ibcw_pkg::ADDR_SCRATCH) begin
        s_d.rdata = s_q.scratch;
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // Bus watchdog
    if (s_q.wd_dis) begin
      s_d.st = ibcw_pkg::WD_IDLE;
      s_d.wd_cnt = '0;
      s_d.bus_free = 1'b0;
    end else begin
      case (s_q.st)
        ibcw_pkg::WD_IDLE: begin
          if (bus_edge) begin
            s_d.wd_cnt = '0;
            s_d.bus_free = 1'b0;
          end else if (s_q.wd_cnt >= wd_lim - 1'b1) begin
            // Quiet for the full interval: decide free or hung by SDA level
            s_d.wd_cnt = '0;
            if (s_q.sda_s) begin
              s_d.bus_free = 1'b1;
            end else begin
              s_d.st = ibcw_pkg::WD_LOW;
              s_d.pulses = 4'h0;
              s_d.half = 8'h00;
            end
          end else begin
            s_d.wd_cnt = s_q.wd_cnt + 1'b1;
          end
        end
        ibcw_pkg::WD_LOW: begin
          if (s_q.half == HALF_LAST) begin
            s_d.half = 8'h00;
            s_d.st = ibcw_pkg::WD_HIGH;
          end else begin
            s_d.half = s_q.half + 8'h01;
          end
        end
        ibcw_pkg::WD_HIGH: begin
          // Clock stretching is not honoured while recovering a hung bus
          if (s_q.half == HALF_LAST) begin
            s_d.half = 8'h00;
            if (s_q.pulses == PULSE_LAST) begin
              s_d.st = ibcw_pkg::WD_IDLE;
              s_d.wd_cnt = '0;
            end else begin
              s_d.pulses = s_q.pulses + 4'h1;
              s_d.st = ibcw_pkg::WD_LOW;
            end
          end else begin
            s_d.half = s_q.half + 8'h01;
          end
        end
        default: begin
          s_d.st = ibcw_pkg::WD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.scratch <= ibcw_pkg::SCRATCH_RESET;
      s_q.scl_m <= 1'b1;
      s_q.scl_s <= 1'b1;
      s_q.scl_p <= 1'b1;
      s_q.sda_m <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.st <= ibcw_pkg::WD_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ibcw_sda_delay u_sda_delay (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sda_low_req(sda_low_req),
    .dly_code(s_q.sda_dly),
    .sda_low_dly(sda_low_dly)
  );

  assign reg_rdata = s_q.rdata;
  assign reg_wr_accept = wr_ok;
  assign reg_wr_blocked = s_q.blocked;
  assign scl_o = 1'b0;
  assign scl_oe = (s_q.st == ibcw_pkg::WD_LOW);
  assign sda_o = 1'b0;
  assign sda_oe = sda_low_dly;
  assign bus_free = s_q.bus_free;
  assign bus_recovering = (s_q.st != ibcw_pkg::WD_IDLE);
  assign scratch_byte = s_q.scratch;
endmodule : ibcw_top
`default_nettype wire

// ==== bench/ibcw_assertions.sv ====
`default_nettype none
module ibcw_assertions #(
  parameter int unsigned WD_LONG_CYCLES = ibcw_pkg::WD_LONG_CYC
) (
  // Clock, reset, registers
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_remote,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_accept,
  input wire logic reg_wr_blocked,
  input wire logic [7:0] scratch_byte,
  // Bus side
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_low_req,
  input wire logic sda_oe,
  input wire logic bus_free,
  input wire logic bus_recovering
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Length of the current SCL low phase, so a short or long recovery pulse shows up
  logic [7:0] low_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 8'h00;
    end else if (!scl_oe) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence bus_edge;
    $changed(scl_i) || $changed(sda_i);
  endsequence
  chk_local_accept: assert property (reg_wr && !reg_remote |-> reg_wr_accept)
    else $error("local write refused");
  chk_block_pulse: assert property (reg_wr && !reg_wr_accept |=> reg_wr_blocked)
    else $error("no blocked pulse");
  chk_block_cause: assert property (reg_wr_blocked |-> $past(reg_wr) && !$past(reg_wr_accept))
    else $error("stray blocked pulse");
  chk_scratch_load: assert property (reg_wr_accept && reg_addr == ibcw_pkg::ADDR_SCRATCH
    |=> scratch_byte == $past(reg_wdata))
    else $error("scratch not loaded");
  chk_sda_early: assert property ($rose(sda_low_req) && !sda_oe |-> !sda_oe [*7])
    else $error("sda driven early");
  chk_recov_scl: assert property (scl_oe |-> bus_recovering)
    else $error("scl driven idle");
  chk_recov_phase: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("short scl low");
  chk_recov_len: assert property ($fell(scl_oe) && bus_recovering
    |-> low_cnt == 8'(ibcw_pkg::RECOV_HALF_CYC))
    else $error("scl low phase length wrong");
  chk_free_edge: assert property (bus_free ##0 bus_edge |-> ##[1:5] !bus_free)
    else $error("free kept after edge");
endmodule : ibcw_assertions
bind ibcw_top ibcw_assertions #(.WD_LONG_CYCLES(WD_LONG_CYCLES)) u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .reg_wr(reg_wr), .reg_remote(reg_remote), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr_accept(reg_wr_accept), .reg_wr_blocked(reg_wr_blocked), .scratch_byte(scratch_byte), .scl_i(scl_i),
  .sda_i(sda_i), .scl_oe(scl_oe), .sda_low_req(sda_low_req), .sda_oe(sda_oe), .bus_free(bus_free),
  .bus_recovering(bus_recovering));
`default_nettype wire

// ==== bench/ibcw_bus_model.sv ====
`default_nettype none
module ibcw_bus_model (
  // Device drives
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Far-side master and stuck slave
  input wire logic mst_scl_low,
  input wire logic slv_sda_low,
  // Resolved lines
  output logic scl_line,
  output logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups: a released line reads high, never the last driven level
  assign scl_line = !(scl_oe || mst_scl_low);
  assign sda_line = !(sda_oe || slv_sda_low);
endmodule : ibcw_bus_model
`default_nettype wire

// ==== bench/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WDL = 2000;
  localparam int WDS = ibcw_pkg::WD_SHORT_CYC;
  logic core_clk = '0, arst_n = '0, reg_wr = '0, reg_rd = '0, reg_remote = '0, seq_err_evt = '0;
  logic sda_low_req = '0, mst = '0, slv = '0, rd_d = '0, scl_i, sda_i, scl_oe, sda_oe;
  logic bus_free, bus_recovering, reg_wr_accept, reg_wr_blocked;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d, exp_q[$];
  int fail_count = 0, num_checks = 0, n, pulses;
  always #25 core_clk = ~core_clk;
  ibcw_top #(.WD_LONG_CYCLES(WDL)) DUT (.core_clk, .arst_n, .reg_wr, .reg_rd, .reg_remote, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_wr_accept, .reg_wr_blocked, .seq_err_evt, .scl_i, .scl_o(), .scl_oe, .sda_i, .sda_o(),
    .sda_oe, .sda_low_req, .bus_free, .bus_recovering, .scratch_byte());
  ibcw_bus_model bus (.scl_oe, .sda_oe, .mst_scl_low(mst), .slv_sda_low(slv), .scl_line(scl_i), .sda_line(sda_i));
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) if (rd_d) chk("reg_rdata", {4'h0, exp_q.pop_front()}, {4'h0, reg_rdata});
  always @(posedge scl_oe) pulses++;
  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] v);
    num_checks++;
    if (v !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic r = 1'h0);
    @(posedge core_clk) {reg_wr, reg_remote, reg_addr, reg_wdata} <= {1'h1, r, a, v};
    @(posedge core_clk) {reg_wr, reg_remote} <= 2'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'h1, a};
    exp_q.push_back(e);
    @(posedge core_clk) reg_rd <= 1'h0;
  endtask : rd
  // Far-side master clocks SCL at the link rate, then leaves the bus quiet
  task automatic frame();
    repeat (8) begin
      repeat (4) @(posedge core_clk);
      mst <= ~mst;
    end
  endtask : frame
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (n = 0; s !== v && n < lim; n++) @(posedge core_clk);
  endtask : wait_for
  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(3490));
    d = 8'($urandom);
    repeat (12) @(posedge core_clk);
    arst_n <= 1'h1;
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h23, ~d, 1'h1);
    rd(8'h23, ~d);
    wr(8'h22, 8'hA4);
    rd(8'h22, 8'h04);
    wr(8'h23, d, 1'h1);
    rd(8'h23, ~d);
    wr(8'h23, d);
    rd(8'h23, d);
    @(posedge core_clk) seq_err_evt <= 1'h1;
    @(posedge core_clk) seq_err_evt <= 1'h0;
    rd(8'h22, 8'h84);
    wr(8'h22, 8'h40);
    rd(8'h22, 8'h40);
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, 8'(c << 3));
      @(posedge core_clk) sda_low_req <= 1'h1;
      for (n = 0; sda_oe !== 1'h1 && n < 20; n++) begin
        @(posedge core_clk);
        #1;
      end
      chk("sda_delay", 12'(ibcw_pkg::SDA_DLY_BASE_CYC + c * ibcw_pkg::SDA_DLY_STEP_CYC), 12'(n));
      @(posedge core_clk) sda_low_req <= 1'h0;
      repeat (20) @(posedge core_clk);
    end
    wr(8'h22, 8'h02);
    frame();
    repeat (600) @(posedge core_clk);
    frame();
    wait_for(bus_free, 1'h1, 3000);
    chk("free_short", 12'h001, 12'(n >= WDS && n <= WDS + 8));
    wr(8'h22, 8'h00);
    frame();
    wait_for(bus_free, 1'h1, 3000);
    chk("free_long", 12'h001, 12'(n >= WDL && n <= WDL + 8));
    wr(8'h22, 8'h03);
    frame();
    repeat (1100) @(posedge core_clk);
    chk("free_disabled", 12'h000, 12'(bus_free));
    wr(8'h22, 8'h02);
    slv <= 1'h1;
    frame();
    pulses = 0;
    wait_for(bus_recovering, 1'h1, 1100);
    wait_for(bus_recovering, 1'h0, 2100);
    chk("recovery_pulses", 12'(ibcw_pkg::RECOV_PULSES), 12'(pulses));
    slv <= 1'h0;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
